// *** rtl/pin_sync.sv ***
// two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] din_i,
  output logic      [W-1:0] dout_o
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= RST_VAL;
      dout_o <= RST_VAL;
    end else begin
      meta   <= din_i;
      dout_o <= meta;
    end
  end

endmodule

// *** rtl/synth_cfg.sv ***
// configuration logic of the programmable synthesizer with its AHB-Lite register slave
`timescale 1ns/1ns
// How it works
// - the output divider divides the oscillator rate by 2, 4, 8 or 1 for codes 00, 01, 10, 11.
// - while the serial load strobe is high the latches follow the shift register (dividers only if parallel strobe is high) and keep its value after it falls.
// - serial data is sampled into the shift register on each rising serial clock edge, valid at that edge.
// - while the parallel load strobe is low the latches follow the divider pins and keep them after it rises.
// - the nine-bit loop divider comes from its pins, bit 8 most significant, captured at the strobe rise.
// - the two-bit output divide select comes from its pins at the strobe rise and sets the divider modulus.
// - the output enable is resynchronised to the divided clock so that no runt pulse appears, low disables.
// - reference select high picks the crystal reference, low picks the external reference.
// - the diagnostic output function is set by a three-bit field loaded only by the serial path.
// - open inputs read low for the serial group, the external reference and the crystal reference, high for all others.
module synth_cfg
  import synth_cfg_pkg::*;
(
  // clock and reset
  input  wire logic                         CLK_I,
  input  wire logic                         RST_I,
  // serial configuration pins
  input  wire logic                         SER_CLOCK_I,
  input  wire logic                         SER_DATA_I,
  input  wire logic                         SER_LOAD_I,
  // parallel configuration pins
  input  wire logic                         PAR_LOAD_N_I,
  input  wire logic [synth_cfg_pkg::M_W-1:0] LOOP_DIV_I,
  input  wire logic [synth_cfg_pkg::N_W-1:0] OUT_DIV_I,
  // enable and reference pins
  input  wire logic                         OUT_ENABLE_I,
  input  wire logic                         REFERENCE_SOURCE_SELECT_I,
  input  wire logic                         EXTERNAL_REFERENCE_IN_I,
  input  wire logic                         XTAL_REF_I,
  // oscillator tick from the loop, same clock
  input  wire logic                         VCO_TICK_I,
  // synthesizer outputs
  output logic                              SYNTH_CLOCK_OUT_O,
  output logic                              REF_CLOCK_O,
  output logic                              FB_PULSE_O,
  output logic                              DIAG_O,
  output logic      [synth_cfg_pkg::M_W-1:0] LOOP_DIV_O,
  output logic      [synth_cfg_pkg::N_W-1:0] OUT_DIV_O,
  // ahb-lite slave
  input  wire logic                         HSEL_I,
  input  wire logic [31:0]                  HADDR_I,
  input  wire logic [1:0]                   HTRANS_I,
  input  wire logic                         HWRITE_I,
  input  wire logic [2:0]                   HSIZE_I,
  input  wire logic [31:0]                  HWDATA_I,
  input  wire logic                         HREADY_I,
  output logic      [31:0]                  HRDATA_O,
  output logic                              HREADYOUT_O,
  output logic                              HRESP_O
);

  // output divide ratio for a code
  function automatic logic [3:0] div_ratio(input logic [N_W-1:0] code);
    unique case (code)
      DIV_BY2: div_ratio = 4'h2;
      DIV_BY4: div_ratio = 4'h4;
      DIV_BY8: div_ratio = 4'h8;
      DIV_BY1: div_ratio = 4'h1;
    endcase
  endfunction

  // synchronised pin bundle
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pin_sync_q;

  // serial path state
  logic               s_clk_d;
  logic [SHIFT_W-1:0] shift;

  // configuration latches
  logic [M_W-1:0] cfg_m;
  logic [N_W-1:0] cfg_n;
  logic [T_W-1:0] cfg_t;
  logic           last_par;

  // dividers and gate
  logic [2:0]     out_cnt;
  logic [M_W-1:0] fb_cnt;
  logic           gate_on;
  logic           synth_q;
  logic           fb_q;
  logic           ref_q;
  logic           diag_q;

  // bus state
  logic [31:0] ctrl;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] rdata;

  // pin bundle, open pins idle at their default levels
  assign pins[PIN_XTAL]               = XTAL_REF_I;
  assign pins[PIN_EXT]                = EXTERNAL_REFERENCE_IN_I;
  assign pins[PIN_SEL]                = REFERENCE_SOURCE_SELECT_I;
  assign pins[PIN_OE]                 = OUT_ENABLE_I;
  assign pins[PIN_N_LO +: N_W]        = OUT_DIV_I;
  assign pins[PIN_M_LO +: M_W]        = LOOP_DIV_I;
  assign pins[PIN_PLD]                = PAR_LOAD_N_I;
  assign pins[PIN_SLD]                = SER_LOAD_I;
  assign pins[PIN_SDAT]               = SER_DATA_I;
  assign pins[PIN_SCLK]               = SER_CLOCK_I;

  // two flops before any logic, reset to the open-pin levels
  pin_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_DEFAULT)
  ) u_pin_sync (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .din_i  (pins),
    .dout_o (pin_sync_q)
  );

  // named synchronised levels
  wire           s_clk_s  = pin_sync_q[PIN_SCLK];
  wire           s_data_s = pin_sync_q[PIN_SDAT];
  wire           s_load_s = pin_sync_q[PIN_SLD];
  wire           p_load_s = ~pin_sync_q[PIN_PLD];
  wire [M_W-1:0] m_s      = pin_sync_q[PIN_M_LO +: M_W];
  wire [N_W-1:0] n_s      = pin_sync_q[PIN_N_LO +: N_W];
  wire           oe_s     = pin_sync_q[PIN_OE];
  wire           sel_s    = pin_sync_q[PIN_SEL];
  wire           ext_s    = pin_sync_q[PIN_EXT];
  wire           xtal_s   = pin_sync_q[PIN_XTAL];

  // serial clock rising edge and shifted fields
  wire           s_rise   = s_clk_s & ~s_clk_d;
  wire [M_W-1:0] sh_m     = shift[SH_M_LO +: M_W];
  wire [N_W-1:0] sh_n     = shift[SH_N_LO +: N_W];
  wire [T_W-1:0] sh_t     = shift[SH_T_LO +: T_W];

  // shift register, new bit enters at the bottom
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_clk_d <= 1'b0;
      shift   <= '0;
    end else begin
      s_clk_d <= s_clk_s;
      if (s_rise) begin
        shift <= {shift[SHIFT_W-2:0], s_data_s};
      end
    end
  end

  // latches: serial transparent while its strobe is high, parallel while low and taking the dividers over serial when both are active
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cfg_m    <= M_RESET;
      cfg_n    <= N_RESET;
      cfg_t    <= T_RESET;
      last_par <= 1'b0;
    end else begin
      if (s_load_s) begin
        cfg_m    <= sh_m;
        cfg_n    <= sh_n;
        cfg_t    <= sh_t;
        last_par <= 1'b0;
      end
      if (p_load_s) begin
        cfg_m    <= m_s;
        cfg_n    <= n_s;
        last_par <= 1'b1;
      end
    end
  end

  // divider terms
  wire [3:0] ratio    = div_ratio(cfg_n);
  wire [2:0] last_cnt = 3'(ratio - 4'h1);
  // a count left above a shortened ratio restarts silently, so no short period reaches the output
  wire       out_end  = out_cnt >= last_cnt;
  wire       out_wrap = VCO_TICK_I && (out_cnt == last_cnt);
  wire       fb_wrap  = VCO_TICK_I && (fb_cnt + 9'h001 >= cfg_m);
  wire       next_gate = out_wrap ? (oe_s & ctrl[CTRL_GATE]) : gate_on;

  // output divider with enable taken only at a period boundary
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      out_cnt <= '0;
      gate_on <= 1'b0;
      synth_q <= 1'b0;
    end else begin
      if (VCO_TICK_I) begin
        out_cnt <= out_end ? 3'h0 : out_cnt + 3'h1;
      end
      gate_on <= next_gate;
      synth_q <= out_wrap & next_gate;
    end
  end

  // loop divider pulse once every cfg_m ticks, every tick when cfg_m is 0
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      fb_cnt <= '0;
      fb_q   <= 1'b0;
    end else begin
      if (VCO_TICK_I) begin
        fb_cnt <= fb_wrap ? '0 : fb_cnt + 9'h001;
      end
      fb_q <= fb_wrap;
    end
  end

  // reference selection and diagnostic function
  wire next_ref = sel_s ? xtal_s : ext_s;
  logic next_diag;
  always_comb begin
    unique case (cfg_t)
      DIAG_LOW:   next_diag = 1'b0;
      DIAG_REF:   next_diag = ref_q;
      DIAG_VCO:   next_diag = VCO_TICK_I;
      DIAG_SYNTH: next_diag = synth_q;
      DIAG_FB:    next_diag = fb_q;
      DIAG_GATE:  next_diag = gate_on;
      DIAG_SDATA: next_diag = s_data_s;
      default:    next_diag = 1'b1;
    endcase
  end

  // registered reference and diagnostic outputs
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ref_q  <= 1'b0;
      diag_q <= 1'b0;
    end else begin
      ref_q  <= next_ref;
      diag_q <= next_diag;
    end
  end

  assign SYNTH_CLOCK_OUT_O = synth_q;
  assign REF_CLOCK_O       = ref_q;
  assign FB_PULSE_O        = fb_q;
  assign DIAG_O            = diag_q;
  assign LOOP_DIV_O        = cfg_m;
  assign OUT_DIV_O         = cfg_n;

  // bus decode, zero wait states and always okay
  wire       ahb_go  = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ);
  wire [7:0] a_off   = HADDR_I[7:0];
  wire       a_hit   = (HADDR_I[31:8] == 24'h000000);
  wire [31:0] status = {16'h0000, last_par, gate_on, cfg_t, cfg_n, cfg_m};
  wire [31:0] rd_mux = !a_hit                 ? 32'h0000_0000 :
                       (a_off == ADDR_CTRL)   ? ctrl :
                       (a_off == ADDR_STATUS) ? status :
                       (a_off == ADDR_SHIFT)  ? {18'h00000, shift} : 32'h0000_0000;
  wire       ctrl_wr = wr_pend && (wr_addr == ADDR_CTRL);

  // address phase capture, read data registered for the data phase
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      rdata   <= '0;
    end else begin
      wr_pend <= ahb_go && HWRITE_I && a_hit;
      wr_addr <= a_off;
      if (ahb_go && !HWRITE_I) begin
        rdata <= rd_mux;
      end
    end
  end

  // control register write in the data phase
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= {31'h00000000, HWDATA_I[CTRL_GATE]};
    end
  end

  assign HRDATA_O    = rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = HRESP_OKAY;

  // checks on the configuration and clock paths
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_shift_on_edge: assert property (
    s_rise |=> shift == {$past(shift[SHIFT_W-2:0]), $past(s_data_s)})
    else $error("shift register missed a serial clock edge");

  a_serial_transparent: assert property (
    s_load_s && !p_load_s |=> cfg_t == $past(sh_t) && cfg_m == $past(sh_m) && cfg_n == $past(sh_n))
    else $error("serial latches not transparent");

  a_diag_field_hold: assert property (
    !s_load_s |=> $stable(cfg_t))
    else $error("diagnostic select changed without serial load");

  a_par_transparent: assert property (
    p_load_s |=> cfg_m == $past(m_s) && cfg_n == $past(n_s))
    else $error("parallel latches not transparent");

  a_latch_hold: assert property (
    !s_load_s && !p_load_s |=> $stable(cfg_m) && $stable(cfg_n))
    else $error("latches changed with no load active");

  a_div_spacing: assert property (
    synth_q |-> $past(out_cnt) == 3'($past(ratio) - 4'h1))
    else $error("output pulse at wrong divider count");

  a_gate_at_edge: assert property (
    $changed(gate_on) |-> $past(out_wrap))
    else $error("output gate changed mid period");

  a_gate_blocks: assert property (
    synth_q |-> gate_on)
    else $error("output pulse while disabled");

  a_ref_select: assert property (
    1'b1 |=> ref_q == ($past(sel_s) ? $past(xtal_s) : $past(ext_s)))
    else $error("wrong reference source");

  a_open_defaults: assert property (
    $past(RST_I) |-> !s_load_s && !p_load_s && oe_s && sel_s)
    else $error("pin defaults wrong after reset");

  a_shift_hold: assert property (
    !s_rise |=> $stable(shift))
    else $error("shift register moved without a serial clock edge");

  a_tick_idle: assert property (
    !VCO_TICK_I |=> !synth_q && !fb_q)
    else $error("divider pulse without an oscillator tick");

  a_div_one: assert property (
    VCO_TICK_I && cfg_n == DIV_BY1 && out_cnt == 3'h0 && oe_s && ctrl[CTRL_GATE] |=> synth_q)
    else $error("divide by one missed a tick");

  a_gate_disable: assert property (
    out_wrap && !(oe_s && ctrl[CTRL_GATE]) |=> !synth_q && !gate_on)
    else $error("output not disabled at period boundary");

  a_diag_ref: assert property (
    cfg_t == DIAG_REF |=> diag_q == $past(ref_q))
    else $error("diagnostic output does not follow the reference");

endmodule

// *** rtl/synth_cfg_pkg.sv ***
// package: constants, field layout and bus map of the synthesizer configuration logic
package synth_cfg_pkg;

  // field widths
  localparam int M_W     = 9;
  localparam int N_W     = 2;
  localparam int T_W     = 3;
  localparam int SHIFT_W = T_W + N_W + M_W;

  // serial word layout, first bit shifted in ends up at the top
  localparam int SH_M_LO = 0;
  localparam int SH_N_LO = M_W;
  localparam int SH_T_LO = M_W + N_W;

  // pin bundle layout passed through the synchroniser
  localparam int PIN_XTAL  = 0;
  localparam int PIN_EXT   = 1;
  localparam int PIN_SEL   = 2;
  localparam int PIN_OE    = 3;
  localparam int PIN_N_LO  = 4;
  localparam int PIN_M_LO  = PIN_N_LO + N_W;
  localparam int PIN_PLD   = PIN_M_LO + M_W;
  localparam int PIN_SLD   = PIN_PLD + 1;
  localparam int PIN_SDAT  = PIN_SLD + 1;
  localparam int PIN_SCLK  = PIN_SDAT + 1;
  localparam int PIN_W     = PIN_SCLK + 1;

  // idle levels of open pins: serial group, external and crystal reference low, the rest high
  localparam logic [PIN_W-1:0] PIN_DEFAULT = 19'h0fffc;

  // configuration reset values, equal to what open pins would load
  localparam logic [M_W-1:0] M_RESET = 9'h1ff;
  localparam logic [N_W-1:0] N_RESET = 2'h3;
  localparam logic [T_W-1:0] T_RESET = 3'h0;

  // output divide codes
  localparam logic [N_W-1:0] DIV_BY2 = 2'h0;
  localparam logic [N_W-1:0] DIV_BY4 = 2'h1;
  localparam logic [N_W-1:0] DIV_BY8 = 2'h2;
  localparam logic [N_W-1:0] DIV_BY1 = 2'h3;

  // diagnostic output functions
  localparam logic [T_W-1:0] DIAG_LOW    = 3'h0;
  localparam logic [T_W-1:0] DIAG_REF    = 3'h1;
  localparam logic [T_W-1:0] DIAG_VCO    = 3'h2;
  localparam logic [T_W-1:0] DIAG_SYNTH  = 3'h3;
  localparam logic [T_W-1:0] DIAG_FB     = 3'h4;
  localparam logic [T_W-1:0] DIAG_GATE   = 3'h5;
  localparam logic [T_W-1:0] DIAG_SDATA  = 3'h6;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SHIFT  = 8'h08;

  // control fields
  localparam int CTRL_GATE = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // status fields
  localparam int ST_M_LO = 0;
  localparam int ST_N_LO = 9;
  localparam int ST_T_LO = 11;
  localparam int ST_GATE = 14;
  localparam int ST_PATH = 15;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// *** sim/cfg_controller_model.sv ***
// external controller model driving the serial and parallel configuration pins
`timescale 1ns/1ns
module cfg_controller_model (
  // clock
  input  wire logic                        clk_i,
  // serial pins
  output logic                             ser_clock_o,
  output logic                             ser_data_o,
  output logic                             ser_load_o,
  // parallel pins
  output logic                             par_load_n_o,
  output logic [synth_cfg_pkg::M_W-1:0]    loop_div_o,
  output logic [synth_cfg_pkg::N_W-1:0]    out_div_o
);
  import synth_cfg_pkg::*;

  // pins start at their open levels
  initial begin
    ser_clock_o = 1'b0;
    ser_data_o = 1'b0;
    ser_load_o = 1'b0;
    par_load_n_o = 1'b1;
    loop_div_o = '1;
    out_div_o = '1;
  end

  // each level stands four cycles so the pin synchroniser sees it
  task automatic hold_cycles(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // shift a word top bit first, then pulse the serial strobe
  task automatic load_serial(input logic [SHIFT_W-1:0] word);
    for (int i = SHIFT_W-1; i >= 0; i--) begin
      ser_data_o <= word[i];
      hold_cycles(4);
      ser_clock_o <= 1'b1;
      hold_cycles(4);
      ser_clock_o <= 1'b0;
    end
    ser_load_o <= 1'b1;
    hold_cycles(4);
    ser_load_o <= 1'b0;
    hold_cycles(4);
    ser_data_o <= 1'b0; // released line drops to its pull-down level
  endtask

  // present divider pins under a low strobe, hold them across its rise
  task automatic load_parallel(input logic [M_W-1:0] m, input logic [N_W-1:0] n);
    par_load_n_o <= 1'b0;
    loop_div_o <= m;
    out_div_o <= n;
    hold_cycles(4);
    par_load_n_o <= 1'b1;
    hold_cycles(4);
    loop_div_o <= '1; // released pins return to their pull-up level
    out_div_o <= '1;
  endtask
endmodule

// *** sim/synth_divider_config_logic_tb.sv ***
// self-checking testbench of the synthesizer configuration logic
`timescale 1ns/1ns
`define CHECK(what, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", what, e, g); end end
module synth_divider_config_logic_tb;
  import synth_cfg_pkg::*;

  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            oe, ref_sel, ext_ref, xtal_ref, vco_tick;
  logic            hsel, hwrite, hreadyout, hresp;
  logic [1:0]      htrans;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  logic            ser_clock, ser_data, ser_load, par_load_n;
  logic [M_W-1:0]  loop_pins, loop_div, m;
  logic [N_W-1:0]  out_pins, out_div, n;
  logic [T_W-1:0]  t, rnd;
  logic            synth_out, ref_out, fb_pulse, diag;
  int              n_mismatch = 0;
  int              n_compared = 0;
  int              seed = 66830;
  int              cnt;

  // 100 MHz clock
  always #5 clk = ~clk;

  cfg_controller_model i_cfg_controller_model (
    .clk_i(clk), .ser_clock_o(ser_clock), .ser_data_o(ser_data), .ser_load_o(ser_load),
    .par_load_n_o(par_load_n), .loop_div_o(loop_pins), .out_div_o(out_pins));

  synth_cfg i_synth_cfg (
    .CLK_I(clk), .RST_I(rst), .SER_CLOCK_I(ser_clock), .SER_DATA_I(ser_data), .SER_LOAD_I(ser_load),
    .PAR_LOAD_N_I(par_load_n), .LOOP_DIV_I(loop_pins), .OUT_DIV_I(out_pins), .OUT_ENABLE_I(oe),
    .REFERENCE_SOURCE_SELECT_I(ref_sel), .EXTERNAL_REFERENCE_IN_I(ext_ref), .XTAL_REF_I(xtal_ref),
    .VCO_TICK_I(vco_tick), .SYNTH_CLOCK_OUT_O(synth_out), .REF_CLOCK_O(ref_out), .FB_PULSE_O(fb_pulse),
    .DIAG_O(diag), .LOOP_DIV_O(loop_div), .OUT_DIV_O(out_div), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
    .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp));

  // output divide ratio of a select code
  function automatic int ratio(input logic [N_W-1:0] fn);
    case (fn)
      DIV_BY2: return 2;
      DIV_BY4: return 4;
      DIV_BY8: return 8;
      default: return 1;
    endcase
  endfunction

  // status word without the gate bit
  function automatic logic [31:0] exp_status(input logic [M_W-1:0] fm, input logic [N_W-1:0] fn,
                                             input logic [T_W-1:0] ft, input logic par);
    return {16'h0, par, 1'b0, ft, fn, fm};
  endfunction

  // one single AHB transfer, entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsel <= 1'b1;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // count output pulses over 64 ticks
  task automatic count_pulses();
    cnt = 0;
    repeat (64) begin
      @(posedge clk);
      if (synth_out === 1'b1) cnt++;
    end
  endtask

  // cycles from one loop divider pulse to the next
  task automatic fb_gap();
    cnt = 0;
    @(posedge clk);
    while (fb_pulse !== 1'b1) @(posedge clk);
    @(posedge clk);
    while (fb_pulse !== 1'b1) begin
      cnt++;
      @(posedge clk);
    end
    cnt++;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    cyc(20000);
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial begin
    {oe, ref_sel, ext_ref, xtal_ref, vco_tick} = 5'h18;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    cyc(12);
    rst <= 1'b0;
    @(posedge clk);
    `CHECK("loop_div", M_RESET, loop_div)
    `CHECK("out_div", DIV_BY1, out_div)
    `CHECK("diag", 1'b0, diag)
    ahb(1'b0, ADDR_CTRL, 32'h0);
    `CHECK("ctrl", CTRL_RESET, rd)
    ahb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    `CHECK("status", exp_status(M_RESET, N_RESET, T_RESET, 1'b0), rd & 32'h0000_3fff)
    ahb(1'b0, 8'h0c, 32'h0);
    `CHECK("unmapped", 32'h0, rd)
    vco_tick <= 1'b1;
    // every divide code through the parallel path
    for (int i = 0; i < 4; i++) begin
      m = M_W'($random(seed));
      n = i[1:0];
      i_cfg_controller_model.load_parallel(m, n);
      cyc(4);
      `CHECK("loop_div", m, loop_div)
      `CHECK("out_div", n, out_div)
      ahb(1'b0, ADDR_STATUS, 32'h0);
      `CHECK("status", exp_status(m, n, T_RESET, 1'b1), rd & 32'h0000_bfff)
      count_pulses();
      `CHECK("pulses", 64 / ratio(n), cnt)
    end
    // enable pin low, then gate bit low, silence the output
    oe <= 1'b0;
    cyc(8);
    count_pulses();
    `CHECK("pulses off pin", 0, cnt)
    oe <= 1'b1;
    ahb(1'b1, ADDR_CTRL, 32'h0);
    cyc(8);
    count_pulses();
    `CHECK("pulses off gate", 0, cnt)
    ahb(1'b1, ADDR_CTRL, CTRL_RESET);
    cyc(8);
    count_pulses();
    `CHECK("pulses on", 64, cnt)
    // serial load with the all-high diagnostic code
    t = 3'h7;
    m = M_W'($random(seed));
    n = N_W'($random(seed));
    i_cfg_controller_model.load_serial({t, n, m});
    cyc(4);
    `CHECK("loop_div", m, loop_div)
    `CHECK("out_div", n, out_div)
    `CHECK("diag", 1'b1, diag)
    ahb(1'b0, ADDR_SHIFT, 32'h0);
    `CHECK("shift", {18'h0, t, n, m}, rd)
    ahb(1'b0, ADDR_STATUS, 32'h0);
    `CHECK("status", exp_status(m, n, t, 1'b0), rd & 32'h0000_bfff)
    // reference selection, mirrored on the diagnostic output
    i_cfg_controller_model.load_serial({DIAG_REF, n, m});
    repeat (8) begin
      rnd = T_W'($random(seed));
      xtal_ref <= rnd[0];
      ext_ref <= rnd[1];
      ref_sel <= rnd[2];
      cyc(5);
      `CHECK("ref", rnd[2] ? rnd[0] : rnd[1], ref_out)
      `CHECK("diag ref", rnd[2] ? rnd[0] : rnd[1], diag)
    end
    // parallel load after serial replaces dividers, keeps the diagnostic code
    m = M_W'($random(seed));
    n = N_W'($random(seed));
    i_cfg_controller_model.load_parallel(m, n);
    cyc(4);
    `CHECK("loop_div", m, loop_div)
    ahb(1'b0, ADDR_STATUS, 32'h0);
    `CHECK("status", exp_status(m, n, DIAG_REF, 1'b1), rd & 32'h0000_bfff)
    `CHECK("out_div", n, out_div)
    // diagnostic codes other than synth and fb: tick and gate high, released serial data and low code low
    for (int k = 0; k < 4; k++) begin
      t = (k == 0) ? DIAG_VCO : (k == 1) ? DIAG_GATE : (k == 2) ? DIAG_SDATA : DIAG_LOW;
      i_cfg_controller_model.load_serial({t, n, m});
      cyc(4);
      `CHECK("diag code", (k < 2) ? 1'b1 : 1'b0, diag)
    end
    // loop divider pulses every m ticks, every tick for 0 and 1
    fb_gap();
    `CHECK("fb gap", (m < 9'h002) ? 1 : int'(m), cnt)
    finish_test();
  end
endmodule
